// >>> inc/btp_consts.vh
`ifndef BTP_CONSTS_VH
`define BTP_CONSTS_VH
// register byte offsets
`define BTP_OFF_RETRY 12'h078
`define BTP_OFF_MTO 12'h080
`define BTP_OFF_HSWAP 12'h0B0
`define BTP_OFF_PMCAP 12'h0DC
`define BTP_OFF_PMCSR 12'h0E0
`define BTP_OFF_ERRSTAT 12'h100
`define BTP_OFF_IRQMASK 12'h104
`define BTP_OFF_TXCTL 12'h108
// reset values
`define BTP_RST_RETRY 32'h01000000
`define BTP_RST_MTO 16'h8000
// fixed read values
`define BTP_HS_NEXT_ON 8'hC0
`define BTP_HS_NEXT_OFF 8'h00
`define BTP_HS_CAPID 8'h06
`define BTP_PM_CAPID 8'h01
`define BTP_PM_NEXT 8'h0B
`define BTP_PM_REV 3'h1
// power states
`define BTP_PS_D0 2'h0
`define BTP_PS_D3 2'h3
// status bit positions
`define BTP_BIT_RETRY_TO 22
`define BTP_BIT_MASTER_TO 23
// length of internal chip reset pulse in clocks
`define BTP_CHIP_RST_CYC 4'h8
`endif

// >>> verilog/btp_regs.v
// Local design decision: the APB slave port.
`timescale 1ns/100ps
`include "btp_consts.vh"
// Behaviour
// RULE1: 32-bit rw retry limit register, reset 0100_0000h.
// RULE2: primary master timeout field bits 15:0, rw, reset 8000h.
// RULE3: secondary master timeout field bits 31:16, rw, reset 8000h.
// RULE4: hot-swap next pointer reads C0h with strap high, else 00h.
// RULE5: rw expansion slot number in bits 20:16, reset zero.
// RULE6: bit 21 rw first-in-chassis flag; bits 23:22 read zero.
// RULE7: rw chassis number byte in bits 31:24, reset zero.
// RULE8: power capability identifier reads 01h.
// RULE9: power capability next pointer reads 0Bh.
// RULE10: power management revision bits 18:16 read 001.
// RULE11: capability bits 31:27, 26:25, 24:22, 21:19 read zero.
// RULE12: rw power state bits 1:0, reset D0; 00 D0, 11 D3.
// RULE13: write of 01 or 10 completes but leaves power state unchanged.
// RULE14: D3 to D0 write pulses internal chip reset, not secondary bus reset.
// RULE15: control/status bits 15:2 read zero.
// RULE16: retry exhaustion asserts system error and sets w1c bit 22.
// RULE17: master timeout before repeat asserts system error and sets w1c bit 23.
// RULE18: counters reload on each queued transaction; timeout flagged at zero.
module btp_regs
(
	input wire clk_in,
	input wire resetn_in,
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [11:0] paddr_in,
	input wire [31:0] pwdata_in,
	input wire [3:0] pstrb_in,
	output reg [31:0] prdata_out,
	output reg pready_out,
	output reg pslverr_out,
	input wire hot_swap_strap_in,
	input wire dt_queued_in,
	input wire dt_primary_in,
	input wire dt_data_in,
	input wire dt_repeated_in,
	output reg upstream_system_error_out,
	output reg chip_reset_out,
	output reg secondary_bus_reset_out,
	output reg irq_out,
	output reg [1:0] power_state_out
);

	reg [31:0] retry_limit_ff;
	reg [15:0] pri_mto_ff;
	reg [15:0] sec_mto_ff;
	reg [4:0] slot_num_ff;
	reg first_chassis_ff;
	reg [7:0] chassis_num_ff;
	reg [1:0] pstate_ff;
	reg retry_to_ff;
	reg master_to_ff;
	reg [1:0] irq_mask_ff;
	reg [31:0] retry_cnt_ff;
	reg [15:0] mto_cnt_ff;
	reg busy_ff;
	reg [3:0] crst_cnt_ff;
	reg strap_s1_ff;
	reg strap_s2_ff;
	reg strap_s3_ff;
	reg strap_ff;
	reg [31:0] nxt_rdata;
	reg nxt_err;

	wire acc = psel_in & penable_in;
	wire wr = acc & pwrite_in;
	wire rd_known = (paddr_in == `BTP_OFF_RETRY) | (paddr_in == `BTP_OFF_MTO) |
		(paddr_in == `BTP_OFF_HSWAP) | (paddr_in == `BTP_OFF_PMCAP) |
		(paddr_in == `BTP_OFF_PMCSR) | (paddr_in == `BTP_OFF_ERRSTAT) |
		(paddr_in == `BTP_OFF_IRQMASK) | (paddr_in == `BTP_OFF_TXCTL);
	wire [1:0] ps_wdata = pwdata_in[1:0];
	wire ps_valid = (ps_wdata == `BTP_PS_D0) | (ps_wdata == `BTP_PS_D3);
	wire ps_wr = wr & pstrb_in[0] & (paddr_in == `BTP_OFF_PMCSR);
	wire retry_hit = busy_ff & ~dt_data_in & (retry_cnt_ff == 32'h00000000);
	wire mto_hit = busy_ff & ~dt_repeated_in & (mto_cnt_ff == 16'h0000);
	wire [1:0] evt = {mto_hit, retry_hit};

	//----------------------------------------
	// strap synchroniser
	//----------------------------------------
	// strap is an external pin, so it is filtered through four flops
	always @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			strap_s1_ff <= 1'b0;
			strap_s2_ff <= 1'b0;
			strap_s3_ff <= 1'b0;
			strap_ff <= 1'b0;
		end
		else
		begin
			strap_s1_ff <= hot_swap_strap_in;
			strap_s2_ff <= strap_s1_ff;
			strap_s3_ff <= strap_s2_ff;
			if (strap_s2_ff == strap_s3_ff)
				strap_ff <= strap_s3_ff;
		end
	end

	//----------------------------------------
	// read mux
	//----------------------------------------
	always @*
	begin
		nxt_rdata = 32'h00000000;
		nxt_err = 1'b0;
		case (paddr_in)
			`BTP_OFF_RETRY: nxt_rdata = retry_limit_ff; // see RULE1
			`BTP_OFF_MTO: nxt_rdata = {sec_mto_ff, pri_mto_ff}; // see RULE2 see RULE3
			`BTP_OFF_HSWAP: nxt_rdata = {chassis_num_ff, 2'b00, first_chassis_ff, slot_num_ff,
				(strap_ff ? `BTP_HS_NEXT_ON : `BTP_HS_NEXT_OFF), `BTP_HS_CAPID}; // see RULE4 see RULE6
			// upper capability bits all zero
			`BTP_OFF_PMCAP: nxt_rdata = {13'h0000, `BTP_PM_REV, `BTP_PM_NEXT, `BTP_PM_CAPID}; // see RULE8 see RULE9 see RULE10 see RULE11
			`BTP_OFF_PMCSR: nxt_rdata = {30'h00000000, pstate_ff}; // see RULE15
			`BTP_OFF_ERRSTAT: nxt_rdata = {8'h00, master_to_ff, retry_to_ff, 22'h000000};
			`BTP_OFF_IRQMASK: nxt_rdata = {8'h00, irq_mask_ff, 22'h000000};
			`BTP_OFF_TXCTL: nxt_rdata = {31'h00000000, busy_ff};
			default: nxt_err = 1'b1;
		endcase
	end

	//----------------------------------------
	// bus response registers
	//----------------------------------------
	// prdata is registered so it appears the cycle after the setup cycle;
	// it is captured during setup so it is valid in the access phase
	always @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			prdata_out <= 32'h00000000;
			pslverr_out <= 1'b0;
			pready_out <= 1'b0;
		end
		else
		begin
			// ready is raised by the setup cycle so every access ends in its
			// first access cycle; it stays a flop so the bus sees no decode glitch
			pready_out <= psel_in & ~penable_in;
			prdata_out <= (psel_in & ~pwrite_in) ? nxt_rdata : 32'h00000000;
			pslverr_out <= psel_in & ~penable_in & ~rd_known;
		end
	end

	//----------------------------------------
	// software writable configuration
	//----------------------------------------
	always @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			retry_limit_ff <= `BTP_RST_RETRY;
			pri_mto_ff <= `BTP_RST_MTO;
			sec_mto_ff <= `BTP_RST_MTO;
			slot_num_ff <= 5'h00;
			first_chassis_ff <= 1'b0;
			chassis_num_ff <= 8'h00;
			irq_mask_ff <= 2'h0;
		end
		else if (wr)
		begin
			case (paddr_in)
				`BTP_OFF_RETRY:
				begin
					if (pstrb_in[0]) retry_limit_ff[7:0] <= pwdata_in[7:0]; // see RULE1
					if (pstrb_in[1]) retry_limit_ff[15:8] <= pwdata_in[15:8];
					if (pstrb_in[2]) retry_limit_ff[23:16] <= pwdata_in[23:16];
					if (pstrb_in[3]) retry_limit_ff[31:24] <= pwdata_in[31:24];
				end
				`BTP_OFF_MTO:
				begin
					if (pstrb_in[0]) pri_mto_ff[7:0] <= pwdata_in[7:0]; // see RULE2
					if (pstrb_in[1]) pri_mto_ff[15:8] <= pwdata_in[15:8];
					if (pstrb_in[2]) sec_mto_ff[7:0] <= pwdata_in[23:16]; // see RULE3
					if (pstrb_in[3]) sec_mto_ff[15:8] <= pwdata_in[31:24];
				end
				`BTP_OFF_HSWAP:
				begin
					if (pstrb_in[2]) slot_num_ff <= pwdata_in[20:16]; // see RULE5
					if (pstrb_in[2]) first_chassis_ff <= pwdata_in[21]; // see RULE6
					if (pstrb_in[3]) chassis_num_ff <= pwdata_in[31:24]; // see RULE7
				end
				`BTP_OFF_IRQMASK:
				begin
					if (pstrb_in[2]) irq_mask_ff <= pwdata_in[23:22];
				end
				default:
				begin
					irq_mask_ff <= irq_mask_ff;
				end
			endcase
		end
	end

	//----------------------------------------
	// power state and internal chip reset
	//----------------------------------------
	// the chip reset is a pulse of fixed length; it does not clear these
	// registers itself, the rest of the bridge consumes it
	always @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			pstate_ff <= `BTP_PS_D0;
			crst_cnt_ff <= 4'h0;
			chip_reset_out <= 1'b0;
			secondary_bus_reset_out <= 1'b0;
			power_state_out <= `BTP_PS_D0;
		end
		else
		begin
			if (ps_wr & ps_valid)
				pstate_ff <= ps_wdata; // see RULE12 see RULE13
			if (ps_wr & (pstate_ff == `BTP_PS_D3) & (ps_wdata == `BTP_PS_D0))
				crst_cnt_ff <= `BTP_CHIP_RST_CYC; // see RULE14
			else if (crst_cnt_ff != 4'h0)
				crst_cnt_ff <= crst_cnt_ff - 4'h1;
			chip_reset_out <= (crst_cnt_ff != 4'h0);
			secondary_bus_reset_out <= 1'b0; // see RULE14
			power_state_out <= pstate_ff;
		end
	end

	//----------------------------------------
	// delayed transaction timers
	//----------------------------------------
	// one tracked transaction at a time; a new queue event restarts both
	always @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			retry_cnt_ff <= 32'h00000000;
			mto_cnt_ff <= 16'h0000;
			busy_ff <= 1'b0;
		end
		else if (dt_queued_in)
		begin
			retry_cnt_ff <= retry_limit_ff; // see RULE18
			mto_cnt_ff <= dt_primary_in ? pri_mto_ff : sec_mto_ff;
			busy_ff <= 1'b1;
		end
		else if (busy_ff)
		begin
			if (dt_repeated_in | retry_hit | mto_hit)
				busy_ff <= 1'b0;
			if (!dt_data_in & (retry_cnt_ff != 32'h00000000))
				retry_cnt_ff <= retry_cnt_ff - 32'h00000001;
			if (mto_cnt_ff != 16'h0000)
				mto_cnt_ff <= mto_cnt_ff - 16'h0001;
		end
	end

	//----------------------------------------
	// error status, interrupt and system error
	//----------------------------------------
	// set wins over a write-one-to-clear in the same cycle
	always @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			retry_to_ff <= 1'b0;
			master_to_ff <= 1'b0;
			irq_out <= 1'b0;
			upstream_system_error_out <= 1'b0;
		end
		else
		begin
			if (retry_hit)
				retry_to_ff <= 1'b1; // see RULE16
			else if (wr & pstrb_in[2] & (paddr_in == `BTP_OFF_ERRSTAT) & pwdata_in[`BTP_BIT_RETRY_TO])
				retry_to_ff <= 1'b0;
			if (mto_hit)
				master_to_ff <= 1'b1; // see RULE17
			else if (wr & pstrb_in[2] & (paddr_in == `BTP_OFF_ERRSTAT) & pwdata_in[`BTP_BIT_MASTER_TO])
				master_to_ff <= 1'b0;
			irq_out <= |({master_to_ff, retry_to_ff} & irq_mask_ff);
			upstream_system_error_out <= |evt; // see RULE16 see RULE17
		end
	end

endmodule

// >>> tb/btp_regs_properties.sv
`timescale 1ns/100ps
// port-level checks of the register block
module btp_regs_properties
(
	input wire clk_in,
	input wire resetn_in,
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [11:0] paddr_in,
	input wire [31:0] pwdata_in,
	input wire [31:0] prdata_out,
	input wire pready_out,
	input wire pslverr_out,
	input wire [3:0] pstrb_in,
	input wire chip_reset_out,
	input wire secondary_bus_reset_out,
	input wire [1:0] power_state_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	// access phase decode shared below
	wire acc = psel_in & penable_in;
	wire rd_acc = acc & !pwrite_in;
	wire ps_wr = acc & pwrite_in & pstrb_in[0] & (paddr_in == 12'h0E0);
	wire ps_bad = ps_wr & (pwdata_in[1:0] == 2'h1 || pwdata_in[1:0] == 2'h2);
	// internal reset runs a fixed length so the core settles before traffic
	sequence s_rst_pulse;
		chip_reset_out [*8] ##1 !chip_reset_out;
	endsequence
	sequence s_rst_start;
		##[1:3] $rose(chip_reset_out);
	endsequence
	a_bad_state_done: assert property (ps_bad |-> pready_out && !pslverr_out)
		else $error("bad state write not completed");
	a_bad_state_keep: assert property (ps_bad |=> ($stable(power_state_out)) [*2])
		else $error("bad state write changed state");
	a_d3_entry: assert property (ps_wr && pwdata_in[1:0] == 2'h3 |-> ##2 power_state_out == 2'h3)
		else $error("d3 not entered");
	a_d0_exit_rst: assert property (ps_wr && pwdata_in[1:0] == 2'h0 && power_state_out == 2'h3 |-> s_rst_start)
		else $error("no chip reset on d3 exit");
	a_rst_pulse_len: assert property ($rose(chip_reset_out) |-> s_rst_pulse)
		else $error("chip reset length wrong");
	a_no_sec_reset: assert property (!secondary_bus_reset_out)
		else $error("secondary reset driven");
	a_pmcap_value: assert property (rd_acc && paddr_in == 12'h0DC |-> prdata_out == 32'h00010B01)
		else $error("power capability word wrong");
	a_pmcsr_zero: assert property (rd_acc && paddr_in == 12'h0E0 |-> prdata_out[15:2] == 14'h0)
		else $error("power control ro bits set");
	a_hs_reserved: assert property (rd_acc && paddr_in == 12'h0B0 |-> prdata_out[23:22] == 2'h0)
		else $error("slot reserved bits set");
endmodule

// >>> tb/btp_apb_host.sv
`timescale 1ns/100ps
// apb requester in the place of the configuration host
module btp_apb_host
(
	input wire clk_in,
	input wire pready_in,
	input wire pslverr_in,
	input wire [31:0] prdata_in,
	output logic psel_out = 1'b0,
	output logic penable_out = 1'b0,
	output logic pwrite_out = 1'b0,
	output logic [11:0] paddr_out = 12'h0,
	output logic [31:0] pwdata_out = 32'h0
);
	logic [31:0] rd_q = 32'h0;
	logic er_q = 1'b0;
	int n_done = 0;
	// answer taken and request released at the ready edge, so no race with registered data
	always @(posedge clk_in)
		if (psel_out && penable_out && pready_in)
		begin
			rd_q <= prdata_in;
			er_q <= pslverr_in;
			psel_out <= 1'b0;
			penable_out <= 1'b0;
			n_done <= n_done + 1;
		end
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
		int k;
		k = n_done;
		@(posedge clk_in);
		psel_out <= 1'b1;
		pwrite_out <= w;
		paddr_out <= a;
		pwdata_out <= d;
		@(posedge clk_in);
		penable_out <= 1'b1;
		wait (n_done != k);
		r = rd_q;
		e = er_q;
	endtask
endmodule

// >>> tb/tb_btp_regs.sv
`timescale 1ns/100ps
module tb_btp_regs;
	logic clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic strap = 1'b1, dt_q = 1'b0, dt_p = 1'b1, dt_d = 1'b0, dt_r = 1'b0, serr_seen = 1'b0, e;
	wire psel, pen, pwr, prdy, perr, serr, crst, sbrst, irq;
	wire [11:0] pa;
	wire [31:0] pwd, prd;
	wire [1:0] pstate;
	logic [31:0] seed = 32'h00010CA6;
	logic [31:0] r;
	int n_mismatch = 0, total_checks = 0;
	always #2.5 clk_in = ~clk_in;
	always @(posedge clk_in) if (serr) serr_seen <= 1'b1;
	btp_regs u_btp_regs
	(
		.clk_in(clk_in), .resetn_in(resetn_in), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
		.paddr_in(pa), .pwdata_in(pwd), .pstrb_in(4'hF), .prdata_out(prd), .pready_out(prdy),
		.pslverr_out(perr), .hot_swap_strap_in(strap), .dt_queued_in(dt_q), .dt_primary_in(dt_p),
		.dt_data_in(dt_d), .dt_repeated_in(dt_r), .upstream_system_error_out(serr), .chip_reset_out(crst),
		.secondary_bus_reset_out(sbrst), .irq_out(irq), .power_state_out(pstate)
	);
	btp_apb_host u_btp_apb_host
	(
		.clk_in(clk_in), .pready_in(prdy), .pslverr_in(perr), .prdata_in(prd), .psel_out(psel),
		.penable_out(pen), .pwrite_out(pwr), .paddr_out(pa), .pwdata_out(pwd)
	);
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function automatic logic unm(input logic [11:0] a);
		return !(a inside {12'h078, 12'h080, 12'h0B0, 12'h0DC, 12'h0E0, 12'h100, 12'h104, 12'h108});
	endfunction
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		total_checks++;
		if (got !== ex)
		begin
			n_mismatch++;
			$display("[ERR] %s exp %h got %h", nm, ex, got);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		u_btp_apb_host.xfer(1'b1, a, d, r, e);
		chk($sformatf("err %h", a), unm(a), e);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] ex);
		u_btp_apb_host.xfer(1'b0, a, 32'h0, r, e);
		chk($sformatf("err %h", a), unm(a), e);
		chk($sformatf("rd %h", a), ex, r & m);
	endtask
	// one delayed transaction held open well past a short limit, then repeated
	task automatic track(input logic dat, input logic pri);
		@(posedge clk_in);
		serr_seen <= 1'b0;
		dt_d <= dat;
		dt_p <= pri;
		dt_q <= 1'b1;
		@(posedge clk_in);
		dt_q <= 1'b0;
		repeat (24) @(posedge clk_in);
		dt_r <= 1'b1;
		@(posedge clk_in);
		dt_r <= 1'b0;
	endtask
	task automatic finish_test;
		if (n_mismatch == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// watchdog: the whole sequence needs well under 5000 cycles
	initial
	begin
		#100us;
		n_mismatch++;
		finish_test();
	end
	initial
	begin
		repeat (8) @(posedge clk_in);
		resetn_in <= 1'b1;
		repeat (6) @(posedge clk_in);
		rd(12'h078, '1, 32'h01000000);
		rd(12'h080, '1, 32'h80008000);
		rd(12'h0B0, 32'hFFFFFF00, 32'h0000C000);
		rd(12'h0DC, '1, 32'h00010B01);
		rd(12'h0E0, 32'h0000FFFF, 32'h0);
		rd(12'h0F0, '1, 32'h0);
		// random data into the 078, 080, 0B0, 0DC and 0E0 words; read-only bits must hold their value
		repeat (4)
		begin
			seed = xs(seed);
			wr(12'h078, seed);
			rd(12'h078, '1, seed);
			wr(12'h080, ~seed);
			rd(12'h080, '1, ~seed);
			wr(12'h0B0, seed);
			rd(12'h0B0, 32'hFFFFFF00, seed & 32'hFF3F0000 | 32'h0000C000);
			wr(12'h0DC, seed);
			rd(12'h0DC, '1, 32'h00010B01);
			wr(12'h0E0, seed & 32'hFFFFFFFC);
			rd(12'h0E0, 32'h0000FFFF, 32'h0);
		end
		strap <= 1'b0;
		repeat (6) @(posedge clk_in);
		rd(12'h0B0, 32'h0000FF00, 32'h0);
		wr(12'h0E0, 32'h3);
		rd(12'h0E0, 32'h3, 32'h3);
		wr(12'h0E0, 32'h1);
		wr(12'h0E0, 32'h2);
		rd(12'h0E0, 32'h3, 32'h3);
		wr(12'h0E0, 32'h0);
		repeat (12) @(posedge clk_in);
		rd(12'h0E0, 32'h3, 32'h0);
		// retry run out, primary timeout, masked retry, secondary timeout
		for (int i = 0; i < 4; i++)
		begin
			wr(12'h104, i == 2 ? 32'h0 : 32'h00C00000);
			wr(12'h080, i == 1 ? 32'h00400005 : i == 3 ? 32'h00050040 : 32'h00400040);
			wr(12'h078, 32'h3);
			track(i[0], i != 3);
			@(negedge clk_in);
			chk("irq", i != 2, irq);
			chk("serr", 1, serr_seen);
			rd(12'h100, 32'h00C00000, i[0] ? 32'h00800000 : 32'h00400000);
			wr(12'h100, 32'h00C00000);
			rd(12'h100, 32'h00C00000, 32'h0);
		end
		finish_test();
	end
endmodule
bind btp_regs btp_regs_properties u_btp_regs_properties
(
	.clk_in(clk_in), .resetn_in(resetn_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
	.paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
	.pslverr_out(pslverr_out), .pstrb_in(pstrb_in), .chip_reset_out(chip_reset_out),
	.secondary_bus_reset_out(secondary_bus_reset_out), .power_state_out(power_state_out)
);
